/* File: rtl/port_stats_pkg.sv */
`default_nettype none
package port_stats_pkg;
	// register byte offsets, 16-bit registers
	localparam logic [11:0] status_off = 12'h514;
	localparam logic [11:0] rsvd_first_off = 12'h516;
	localparam logic [11:0] rsvd_last_off = 12'h560;
	localparam logic [11:0] ictl_off = 12'h4a0;
	localparam logic [11:0] data_low_off = 12'h4a8;
	localparam logic [11:0] data_high_off = 12'h4aa;

	// status word fields
	localparam int variant_bit = 15;
	localparam logic variant_reset = 1'b0;
	localparam logic [15:0] status_reset = 16'h0000;

	// indirect control fields
	localparam int ctl_read_bit = 12;
	localparam int ctl_addr_msb = 9;
	localparam int ctl_port_lsb = 5;
	localparam logic [15:0] ctl_reset = 16'h0000;

	// counter word fields
	localparam int cnt_width = 30;
	localparam int ovf_bit = 31;
	localparam int valid_bit = 30;
	localparam logic [31:0] word_reset = 32'h0000_0000;
	localparam int counter_count = 32;

	// counter indices
	localparam int idx_octets = 0;
	localparam int idx_short_good = 2;
	localparam int idx_short_bad = 3;
	localparam int idx_long_good = 4;
	localparam int idx_long_bad = 5;
	localparam int idx_symbol = 6;
	localparam int idx_checksum = 7;
	localparam int idx_misaligned = 8;
	localparam int idx_mac_ctrl = 9;
	localparam int idx_pause = 10;
	localparam int idx_bcast = 11;
	localparam int idx_mcast = 12;
	localparam int idx_ucast = 13;
	localparam int idx_len_bin_first = 14;

	// frame length limits in octets
	localparam int len_width = 11;
	localparam logic [10:0] min_frame_len = 11'h040;
	localparam logic [10:0] max_std_len = 11'h5f2;
	localparam logic [10:0] max_long_len = 11'h600;
	localparam logic [10:0] bin_edge_128 = 11'h080;
	localparam logic [10:0] bin_edge_256 = 11'h100;
	localparam logic [10:0] bin_edge_512 = 11'h200;
	localparam logic [10:0] bin_edge_1024 = 11'h400;

	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_fetch = 1'b1
	} fetch_state_type;

	// order matches status bits 13 down to 0
	typedef struct packed {
		logic polarity_rev;
		logic rx_fc_active;
		logic tx_fc_active;
		logic speed_100;
		logic full_duplex;
		logic far_fault;
		logic mdix_state;
		logic an_done;
		logic link_good;
		logic [4:0] partner_abil;
	} phy_status_type;

	typedef struct packed {
		logic done;
		logic [10:0] len;
		logic crc_ok;
		logic symbol_err;
		logic odd_bits;
		logic bcast;
		logic mcast;
		logic mac_ctrl;
		logic pause_match;
	} rx_frame_type;
endpackage
`default_nettype wire

/* File: rtl/port_stats.sv */
`timescale 1ns/1ps
`default_nettype none
module port_stats (
	input wire logic clk,
	input wire logic arst_n,
	input wire port_stats_pkg::phy_status_type phy_pins,
	input wire port_stats_pkg::rx_frame_type rx_frame,
	input wire logic max_1536_sel,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rd_ack,
	output logic crossover_variant_select
);

	function automatic logic in_range(input logic [10:0] v, input logic [10:0] lo, input logic [10:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	// base is zero when the counter is read this cycle, so an event in that cycle still lands
	function automatic logic [30:0] next_count(input logic [30:0] old, input logic clr, input logic [29:0] amt);
		logic [30:0] base;
		logic [30:0] sum;
		base = clr ? 31'h0000_0000 : old;
		sum = {1'b0, base[29:0]} + {1'b0, amt};
		next_count = {base[30] | sum[30], sum[29:0]};
	endfunction

	port_stats_pkg::phy_status_type sync1_q, sync2_q, sync3_q, filt_q;
	logic variant_q;
	logic [15:0] ctl_q;
	logic [9:0] sel_q;
	logic [31:0] word_q;
	logic [30:0] cnt_q [port_stats_pkg::counter_count];
	port_stats_pkg::fetch_state_type state_q;
	logic [15:0] rdata_q;
	logic ack_q;

	logic [13:0] agree;
	logic [10:0] limit;
	logic [10:0] flen;
	logic len_ok;
	logic bad_frame;
	logic good_frame;
	logic [31:0] hit;
	logic trigger;
	logic sel_in_port;
	logic clr_now;
	logic [15:0] status_word;

	// three-stage capture of the phy levels; a bit is accepted once stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= phy_pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign agree = ~(sync2_q ^ sync3_q);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			filt_q <= '0;
		end else begin
			filt_q <= port_stats_pkg::phy_status_type'((sync2_q & agree) | (filt_q & ~agree));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			variant_q <= port_stats_pkg::variant_reset;
		end else if (reg_wr && reg_addr == port_stats_pkg::status_off) begin
			variant_q <= reg_wdata[port_stats_pkg::variant_bit];
		end
	end

	assign crossover_variant_select = variant_q;

	// partner abilities, bits 4-0
	// bit 14 is reserved and reads zero
	assign status_word = {variant_q, 1'b0, filt_q};

	// frame classification
	assign limit = max_1536_sel ? port_stats_pkg::max_long_len : port_stats_pkg::max_std_len;
	assign flen = rx_frame.len;
	assign len_ok = in_range(flen, port_stats_pkg::min_frame_len, limit);
	assign bad_frame = !rx_frame.crc_ok || rx_frame.symbol_err;
	assign good_frame = len_ok && !bad_frame;

	always_comb begin
		hit = 32'h0000_0000;
		if (rx_frame.done) begin
			hit[port_stats_pkg::idx_octets] = 1'b1;
			hit[port_stats_pkg::idx_short_good] = (flen < port_stats_pkg::min_frame_len) && rx_frame.crc_ok
				&& !rx_frame.symbol_err;
			hit[port_stats_pkg::idx_short_bad] = (flen < port_stats_pkg::min_frame_len)
				&& (bad_frame || rx_frame.odd_bits);
			hit[port_stats_pkg::idx_long_good] = (flen > limit) && !bad_frame;
			hit[port_stats_pkg::idx_long_bad] = (flen > limit) && (bad_frame || rx_frame.odd_bits);
			hit[port_stats_pkg::idx_symbol] = len_ok && rx_frame.symbol_err;
			hit[port_stats_pkg::idx_checksum] = len_ok && !rx_frame.crc_ok && !rx_frame.symbol_err
				&& !rx_frame.odd_bits;
			hit[port_stats_pkg::idx_misaligned] = len_ok && !rx_frame.crc_ok && !rx_frame.symbol_err
				&& rx_frame.odd_bits;
			hit[port_stats_pkg::idx_mac_ctrl] = rx_frame.mac_ctrl;
			hit[port_stats_pkg::idx_pause] = rx_frame.pause_match && rx_frame.crc_ok
				&& (flen >= port_stats_pkg::min_frame_len);
			hit[port_stats_pkg::idx_bcast] = good_frame && rx_frame.bcast;
			hit[port_stats_pkg::idx_mcast] = good_frame && rx_frame.mcast && !rx_frame.bcast
				&& !rx_frame.mac_ctrl;
			hit[port_stats_pkg::idx_ucast] = good_frame && !rx_frame.bcast && !rx_frame.mcast;
			hit[port_stats_pkg::idx_len_bin_first] = (flen == port_stats_pkg::min_frame_len);
			hit[port_stats_pkg::idx_len_bin_first + 1] = in_range(flen, port_stats_pkg::min_frame_len + 11'h001,
				port_stats_pkg::bin_edge_128 - 11'h001);
			hit[port_stats_pkg::idx_len_bin_first + 2] = in_range(flen, port_stats_pkg::bin_edge_128,
				port_stats_pkg::bin_edge_256 - 11'h001);
			hit[port_stats_pkg::idx_len_bin_first + 3] = in_range(flen, port_stats_pkg::bin_edge_256,
				port_stats_pkg::bin_edge_512 - 11'h001);
			hit[port_stats_pkg::idx_len_bin_first + 4] = in_range(flen, port_stats_pkg::bin_edge_512,
				port_stats_pkg::bin_edge_1024 - 11'h001);
			hit[port_stats_pkg::idx_len_bin_first + 5] = in_range(flen, port_stats_pkg::bin_edge_1024, limit);
		end
	end

	assign trigger = reg_wr && reg_addr == port_stats_pkg::ictl_off && reg_wdata[port_stats_pkg::ctl_read_bit];
	assign sel_in_port = (sel_q[port_stats_pkg::ctl_addr_msb:port_stats_pkg::ctl_port_lsb] == 5'h00);
	// a trigger during a fetch abandons that read, so its counter is not cleared unseen
	assign clr_now = (state_q == port_stats_pkg::st_fetch) && sel_in_port && !trigger;

	// control register holds address and selection
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_q <= port_stats_pkg::ctl_reset;
			sel_q <= 10'h000;
		end else if (reg_wr && reg_addr == port_stats_pkg::ictl_off) begin
			ctl_q <= reg_wdata;
			sel_q <= reg_wdata[port_stats_pkg::ctl_addr_msb:0];
		end
	end

	// one write both addresses and starts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= port_stats_pkg::st_idle;
		end else begin
			case (state_q)
				port_stats_pkg::st_idle: begin
					if (trigger) begin
						state_q <= port_stats_pkg::st_fetch;
					end
				end
				port_stats_pkg::st_fetch: begin
					state_q <= trigger ? port_stats_pkg::st_fetch : port_stats_pkg::st_idle;
				end
				default: begin
					state_q <= port_stats_pkg::st_idle;
				end
			endcase
		end
	end

	// counter bank; wrap sets overflow, read clears it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < port_stats_pkg::counter_count; i++) begin
				cnt_q[i] <= 31'h0000_0000;
			end
		end else begin
			for (int i = 0; i < port_stats_pkg::counter_count; i++) begin
				cnt_q[i] <= next_count(cnt_q[i], clr_now && (sel_q[4:0] == 5'(i)),
					(i == port_stats_pkg::idx_octets) ? {19'h00000, flen & {11{hit[i]}}} : {29'h00000000, hit[i]});
			end
		end
	end

	// word capture; valid stays low while the fetch is pending
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_q <= port_stats_pkg::word_reset;
		end else if (trigger) begin
			word_q[port_stats_pkg::valid_bit] <= 1'b0;
		end else if (state_q == port_stats_pkg::st_fetch) begin
			// out-of-port addresses return a valid zero word
			word_q <= sel_in_port ? {cnt_q[sel_q[4:0]][30], 1'b1, cnt_q[sel_q[4:0]][29:0]} : 32'h4000_0000;
		end
	end

	// split data registers; reserved and unmapped read zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= port_stats_pkg::status_reset;
			ack_q <= 1'b0;
		end else begin
			ack_q <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					port_stats_pkg::status_off: begin
						rdata_q <= status_word;
					end
					port_stats_pkg::ictl_off: begin
						rdata_q <= ctl_q;
					end
					port_stats_pkg::data_low_off: begin
						rdata_q <= word_q[15:0];
					end
					port_stats_pkg::data_high_off: begin
						rdata_q <= word_q[31:16];
					end
					default: begin
						rdata_q <= 16'h0000;
					end
				endcase
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rd_ack = ack_q;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_trigger;
		trigger && state_q == port_stats_pkg::st_idle;
	endsequence

	sequence s_fetch_done;
		!word_q[port_stats_pkg::valid_bit] ##1 word_q[port_stats_pkg::valid_bit];
	endsequence

	a_variant_write: assert property (
		reg_wr && reg_addr == port_stats_pkg::status_off |=> crossover_variant_select == $past(reg_wdata[15]))
		else $error("variant select did not follow write");

	a_status_read: assert property (
		reg_rd && reg_addr == port_stats_pkg::status_off |=> reg_rd_ack && reg_rdata[13:0] == $past(filt_q)
			&& !reg_rdata[14])
		else $error("status read mismatch");

	a_reserved_zero: assert property (
		reg_rd && reg_addr >= port_stats_pkg::rsvd_first_off && reg_addr <= port_stats_pkg::rsvd_last_off
			|=> reg_rdata == 16'h0000)
		else $error("reserved location not zero");

	a_fetch_valid: assert property (
		s_trigger ##1 !trigger |-> s_fetch_done)
		else $error("valid flag sequence wrong after trigger");

	a_data_split: assert property (
		state_q == port_stats_pkg::st_fetch && !trigger && sel_in_port
			|=> word_q[29:0] == $past(cnt_q[sel_q[4:0]][29:0]) && word_q[31] == $past(cnt_q[sel_q[4:0]][30]))
		else $error("captured word differs from counter");

	a_read_clears: assert property (
		clr_now && !rx_frame.done |=> cnt_q[$past(sel_q[4:0])] == 31'h0000_0000)
		else $error("counter not cleared by read");

	a_octet_sum: assert property (
		rx_frame.done && !(clr_now && sel_q[4:0] == 5'h00) && cnt_q[0][29:0] < 30'h3fff_f800
			|=> cnt_q[0][29:0] == $past(cnt_q[0][29:0]) + {19'h00000, $past(flen)})
		else $error("octet total wrong");

	a_overflow_set: assert property (
		cnt_q[2][29:0] == 30'h3fff_ffff && hit[2] && !(clr_now && sel_q[4:0] == 5'h02)
			|=> cnt_q[2][30] && cnt_q[2][29:0] == 30'h0000_0000)
		else $error("overflow flag not set on wrap");

	a_pause_count: assert property (
		rx_frame.done && rx_frame.pause_match && rx_frame.crc_ok && flen >= 11'h040 && !clr_now
			&& cnt_q[10][29:0] != 30'h3fff_ffff |=> cnt_q[10][29:0] == $past(cnt_q[10][29:0]) + 30'h0000_0001)
		else $error("pause frame not counted");

	a_overflow_quiet: assert property (
		!cnt_q[2][30] && cnt_q[2][29:0] != 30'h3fff_ffff |=> !cnt_q[2][30])
		else $error("overflow flag set without wrap");

	a_high_read: assert property (
		reg_rd && reg_addr == port_stats_pkg::data_high_off |=> reg_rdata == $past(word_q[31:16]))
		else $error("upper data half mismatch");

	a_low_read: assert property (
		reg_rd && reg_addr == port_stats_pkg::data_low_off |=> reg_rdata == $past(word_q[15:0]))
		else $error("lower data half mismatch");

	a_ctl_readback: assert property (
		reg_rd && reg_addr == port_stats_pkg::ictl_off |=> reg_rdata == $past(ctl_q))
		else $error("control register readback mismatch");

	a_variant_hold: assert property (
		!(reg_wr && reg_addr == port_stats_pkg::status_off) |=> $stable(crossover_variant_select))
		else $error("variant select changed without write");

	a_bcast_count: assert property (
		rx_frame.done && len_ok && rx_frame.crc_ok && !rx_frame.symbol_err && rx_frame.bcast && !clr_now
			&& cnt_q[11][29:0] != 30'h3fff_ffff |=> cnt_q[11][29:0] == $past(cnt_q[11][29:0]) + 30'h0000_0001)
		else $error("broadcast frame not counted");

	a_bin_count: assert property (
		rx_frame.done && flen == 11'h040 && !clr_now
			&& cnt_q[14][29:0] != 30'h3fff_ffff |=> cnt_q[14][29:0] == $past(cnt_q[14][29:0]) + 30'h0000_0001)
		else $error("minimum length frame not binned");

endmodule
`default_nettype wire

/* File: tb/port_stats_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module port_stats_bench;
	// flags: crc_ok, symbol, odd, bcast, mcast, ctrl, pause
	typedef struct packed {
		logic [10:0] len;
		logic [6:0] fl;
		logic sel;
		logic [4:0] idx;
		logic [29:0] cnt;
	} row_type;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	port_stats_pkg::phy_status_type phy_pins = '0;
	port_stats_pkg::rx_frame_type rx_frame = '0;
	logic max_1536_sel = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic reg_rd_ack;
	logic crossover_variant_select;
	int mismatches = 0;
	int n_tests = 0;
	logic [15:0] h;
	logic [31:0] w;
	row_type rows [25];
	logic [11:0] dead [4] = '{12'h516, 12'h53a, 12'h560, 12'h7fe};

	always #50 clk = ~clk;

	port_stats u_dut (
		.clk(clk),
		.arst_n(arst_n),
		.phy_pins(phy_pins),
		.rx_frame(rx_frame),
		.max_1536_sel(max_1536_sel),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rd_ack(reg_rd_ack),
		.crossover_variant_select(crossover_variant_select)
	);

	function automatic row_type mk(logic [10:0] l, logic [6:0] f, int s, logic [4:0] i, int c);
		return '{len: l, fl: f, sel: 1'(s), idx: i, cnt: 30'(c)};
	endfunction

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: reg got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: word got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#10;
		reg_wr = 1'b0;
	endtask

	// ack is registered, so it is up just after the edge that took the strobe
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#10;
		reg_rd = 1'b0;
		chk16({15'h0000, reg_rd_ack}, 16'h0001);
		d = reg_rdata;
	endtask

	task automatic rd_word(input logic [9:0] a, output logic [31:0] v);
		logic [15:0] hi;
		logic [15:0] lo;
		wr(port_stats_pkg::ictl_off, 16'h1000 | {6'h00, a});
		rd(port_stats_pkg::data_high_off, hi);
		rd(port_stats_pkg::data_low_off, lo);
		v = {hi, lo};
	endtask

	// every in-port read clears, so a sweep leaves all counters at zero
	task automatic clear_all();
		for (int i = 0; i < 32; i++) begin
			rd_word(10'(i), w);
		end
	endtask

	task automatic frame(input row_type r);
		@(posedge clk);
		#10;
		max_1536_sel = r.sel;
		rx_frame = {1'b1, r.len, r.fl};
		@(posedge clk);
		#10;
		rx_frame.done = 1'b0;
	endtask

	task automatic wrap_up();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(30000 * 100);
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		rows = '{mk(11'h040, 7'h40, 0, 5'h0d, 1), mk(11'h040, 7'h40, 0, 5'h0e, 1),
			mk(11'h064, 7'h40, 0, 5'h0f, 1), mk(11'h0c8, 7'h40, 0, 5'h10, 1),
			mk(11'h12c, 7'h40, 0, 5'h11, 1), mk(11'h3ff, 7'h40, 0, 5'h12, 1),
			mk(11'h400, 7'h40, 0, 5'h13, 1), mk(11'h064, 7'h00, 0, 5'h00, 100),
			mk(11'h028, 7'h40, 0, 5'h02, 1), mk(11'h028, 7'h00, 0, 5'h03, 1),
			mk(11'h640, 7'h40, 0, 5'h04, 1), mk(11'h640, 7'h00, 0, 5'h05, 1),
			mk(11'h5fa, 7'h40, 0, 5'h04, 1), mk(11'h5fa, 7'h40, 1, 5'h04, 0),
			mk(11'h064, 7'h20, 0, 5'h06, 1), mk(11'h064, 7'h20, 0, 5'h07, 0),
			mk(11'h064, 7'h00, 0, 5'h07, 1), mk(11'h064, 7'h10, 0, 5'h08, 1),
			mk(11'h064, 7'h42, 0, 5'h09, 1), mk(11'h040, 7'h43, 0, 5'h0a, 1),
			mk(11'h064, 7'h48, 0, 5'h0b, 1), mk(11'h064, 7'h44, 0, 5'h0c, 1),
			mk(11'h064, 7'h46, 0, 5'h0c, 0), mk(11'h064, 7'h08, 0, 5'h0b, 0),
			mk(11'h064, 7'h00, 0, 5'h0d, 0)};
		repeat (12) @(posedge clk);
		#10;
		arst_n = 1'b1;
		rd(port_stats_pkg::status_off, h);
		chk16(h, port_stats_pkg::status_reset);
		rd_word(10'h00e, w);
		chk32(w, 32'h4000_0000);
		foreach (rows[i]) begin
			clear_all();
			frame(rows[i]);
			rd_word({5'h00, rows[i].idx}, w);
			chk32(w, {2'h1, rows[i].cnt});
		end
		for (int b = 0; b < 14; b++) begin
			phy_pins = 14'h0001 << b;
			repeat (6) @(posedge clk);
			rd(port_stats_pkg::status_off, h);
			chk16(h, 16'h0001 << b);
		end
		phy_pins = '0;
		repeat (6) @(posedge clk);
		wr(port_stats_pkg::status_off, 16'hffff);
		rd(port_stats_pkg::status_off, h);
		chk16(h, 16'h8000);
		chk16({15'h0000, crossover_variant_select}, 16'h0001);
		wr(port_stats_pkg::status_off, 16'h0000);
		rd(port_stats_pkg::status_off, h);
		chk16(h, 16'h0000);
		foreach (dead[i]) begin
			wr(dead[i], 16'hffff);
			rd(dead[i], h);
			chk16(h, 16'h0000);
		end
		// read issued in the cycle straight after the trigger sees valid low
		clear_all();
		frame(rows[0]);
		@(posedge clk);
		#10;
		reg_addr = port_stats_pkg::ictl_off;
		reg_wdata = 16'h100d;
		reg_wr = 1'b1;
		@(posedge clk);
		#10;
		reg_wr = 1'b0;
		reg_addr = port_stats_pkg::data_high_off;
		reg_rd = 1'b1;
		@(posedge clk);
		#10;
		reg_rd = 1'b0;
		chk16(reg_rdata & 16'h4000, 16'h0000);
		rd(port_stats_pkg::data_high_off, h);
		chk16(h, 16'h4000);
		rd(port_stats_pkg::data_low_off, h);
		chk16(h, 16'h0001);
		rd_word(10'h00d, w);
		chk32(w, 32'h4000_0000);
		rd_word(10'h02e, w);
		chk32(w, 32'h4000_0000);
		rd_word(10'h00e, w);
		chk32(w, 32'h4000_0001);
		wr(port_stats_pkg::ictl_off, 16'h0c0d);
		rd(port_stats_pkg::ictl_off, h);
		chk16(h, 16'h0c0d);
		rd(port_stats_pkg::data_low_off, h);
		chk16(h, 16'h0001);
		@(posedge clk);
		#10;
		rx_frame = {1'h1, 11'h064, 7'h40};
		@(posedge clk);
		#10;
		rx_frame = {1'h1, 11'h0c8, 7'h40};
		@(posedge clk);
		#10;
		rx_frame.done = 1'b0;
		rd_word(10'h000, w);
		chk32(w, 32'h4000_016c);
		// second reset in mid-run
		phy_pins = 14'h3fff;
		wr(port_stats_pkg::status_off, 16'h8000);
		frame(rows[0]);
		@(posedge clk);
		#10;
		arst_n = 1'b0;
		phy_pins = '0;
		#10;
		chk16({15'h0000, crossover_variant_select}, 16'h0000);
		chk16(reg_rdata, 16'h0000);
		chk16({15'h0000, reg_rd_ack}, 16'h0000);
		repeat (3) @(posedge clk);
		#10;
		arst_n = 1'b1;
		rd(port_stats_pkg::status_off, h);
		chk16(h, 16'h0000);
		rd_word(10'h00d, w);
		chk32(w, 32'h4000_0000);
		wrap_up();
	end
endmodule
`default_nettype wire
